// ==== jcr_pkg.sv ====
// Purpose: Shared constants, types and the test-port state table for the
//          configuration readback block.
// Assumes: 16-bit configuration words, 6-bit instruction register.
// Notes:   Overview of the numbered behaviour follows.
//
// Overview of operation
// - Input instruction low bits 00101 shift LSB-first
// - Instruction MSB latched on Shift-IR exit
// - Status read packets shift in MSB first
// - Last packet LSB taken on Shift-DR exit
// - Output instruction 00100 loads like input one
// - Status shifts out on TDO, sixteen bits
// - Same packet parsing as parallel port
// - Frame readback emits one dummy frame first
// - Shutdown completes within 24 idle TCKs
// - Done output low during shutdown
package jcr_pkg;
   localparam logic [5:0]  INSTR_CFG_IN   = 6'h05;
   localparam logic [5:0]  INSTR_CFG_OUT  = 6'h04;
   localparam logic [5:0]  INSTR_SHUTDOWN = 6'h0d;
   localparam logic [5:0]  INSTR_BYPASS   = 6'h3f;
   localparam logic [5:0]  IR_CAPTURE     = 6'h01;
   localparam logic [15:0] SYNC_HI        = 16'haa99;
   localparam logic [15:0] SYNC_LO        = 16'h5566;
   localparam logic [15:0] CMD_READ_CFG   = 16'h0004;
   localparam logic [2:0]  PKT_TYPE1      = 3'h1;
   localparam logic [2:0]  PKT_TYPE2      = 3'h2;
   localparam logic [1:0]  OP_READ        = 2'h1;
   localparam logic [1:0]  OP_WRITE       = 2'h2;
   localparam logic [5:0]  REG_FRAME_OUT  = 6'h03;
   localparam logic [5:0]  REG_CMD        = 6'h05;
   localparam logic [5:0]  REG_STAT       = 6'h08;
   // Shutdown length in TCK cycles
   localparam logic [4:0]  SHUTDOWN_TCK   = 5'h18;
   localparam logic [3:0]  WORD_LAST      = 4'hf;
   localparam int          ST_SYNC        = 0;
   localparam int          ST_SHUT        = 1;
   localparam int          ST_DONE        = 2;
   localparam int          ST_READ_CFG    = 3;
   localparam int          ST_OVR         = 4;

   typedef enum logic [15:0] {
      TS_TLR      = 16'h0001,
      TS_RTI      = 16'h0002,
      TS_SEL_DR   = 16'h0004,
      TS_CAP_DR   = 16'h0008,
      TS_SHIFT_DR = 16'h0010,
      TS_EX1_DR   = 16'h0020,
      TS_PAUSE_DR = 16'h0040,
      TS_EX2_DR   = 16'h0080,
      TS_UPD_DR   = 16'h0100,
      TS_SEL_IR   = 16'h0200,
      TS_CAP_IR   = 16'h0400,
      TS_SHIFT_IR = 16'h0800,
      TS_EX1_IR   = 16'h1000,
      TS_PAUSE_IR = 16'h2000,
      TS_EX2_IR   = 16'h4000,
      TS_UPD_IR   = 16'h8000
   } jcr_tap_t;

   typedef enum logic [2:0] {
      PS_HUNT = 3'h1,
      PS_HDR  = 3'h2,
      PS_DATA = 3'h4
   } jcr_pst_t;

   typedef enum logic [1:0] {
      RS_STAT  = 2'h1,
      RS_FRAME = 2'h2
   } jcr_rsel_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } jcr_pins_t;

   typedef struct packed {
      logic [2:0] ptype;
      logic [1:0] op;
      logic [5:0] addr;
      logic [4:0] cnt;
   } jcr_hdr_t;

   function automatic jcr_tap_t jcr_next_tap(input jcr_tap_t s, input logic tms);
      jcr_tap_t n;
      n = TS_TLR;
      case (s)
         TS_TLR:      n = tms ? TS_TLR : TS_RTI;
         TS_RTI:      n = tms ? TS_SEL_DR : TS_RTI;
         TS_SEL_DR:   n = tms ? TS_SEL_IR : TS_CAP_DR;
         TS_CAP_DR:   n = tms ? TS_EX1_DR : TS_SHIFT_DR;
         TS_SHIFT_DR: n = tms ? TS_EX1_DR : TS_SHIFT_DR;
         TS_EX1_DR:   n = tms ? TS_UPD_DR : TS_PAUSE_DR;
         TS_PAUSE_DR: n = tms ? TS_EX2_DR : TS_PAUSE_DR;
         TS_EX2_DR:   n = tms ? TS_UPD_DR : TS_SHIFT_DR;
         TS_UPD_DR:   n = tms ? TS_SEL_DR : TS_RTI;
         TS_SEL_IR:   n = tms ? TS_TLR : TS_CAP_IR;
         TS_CAP_IR:   n = tms ? TS_EX1_IR : TS_SHIFT_IR;
         TS_SHIFT_IR: n = tms ? TS_EX1_IR : TS_SHIFT_IR;
         TS_EX1_IR:   n = tms ? TS_UPD_IR : TS_PAUSE_IR;
         TS_PAUSE_IR: n = tms ? TS_EX2_IR : TS_PAUSE_IR;
         TS_EX2_IR:   n = tms ? TS_UPD_IR : TS_SHIFT_IR;
         TS_UPD_IR:   n = tms ? TS_SEL_DR : TS_RTI;
         default:     n = TS_TLR;
      endcase
      return n;
   endfunction
endpackage

// ==== jcr_sync.sv ====
// Purpose: Two-flop synchroniser for the test-port pins.
// Assumes: Inputs are asynchronous to clk.
// Notes:   Only the second stage is visible outside.
module jcr_sync #(
   parameter int W = 3
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } jcr_sync_t;

   jcr_sync_t st_ff;
   jcr_sync_t nxt_st;

   always_comb begin
      nxt_st    = st_ff;
      nxt_st.s1 = din;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign dout = st_ff.s2;
endmodule // jcr_sync

// ==== jcr_buf.sv ====
// Purpose: Two-entry word buffer between the shift path and the parser.
// Assumes: Single clock; valid/ready on both sides.
// Notes:   Read data come straight from the head register.
module jcr_buf #(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   typedef struct packed {
      logic             head_v;
      logic [WIDTH-1:0] head_d;
      logic             spare_v;
      logic [WIDTH-1:0] spare_d;
   } jcr_buf_t;

   jcr_buf_t st_ff;
   jcr_buf_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (st_ff.head_v && out_ready) begin
         nxt_st.head_v = 1'h0;
         if (st_ff.spare_v) begin
            nxt_st.head_d  = st_ff.spare_d;
            nxt_st.head_v  = 1'h1;
            nxt_st.spare_v = 1'h0;
         end
      end
      if (in_valid && !st_ff.spare_v) begin
         if (!nxt_st.head_v) begin
            nxt_st.head_d = in_data;
            nxt_st.head_v = 1'h1;
         end else begin
            nxt_st.spare_d = in_data;
            nxt_st.spare_v = 1'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Full means the spare slot is taken; the head may still drain
   assign in_ready  = !st_ff.spare_v;
   assign out_valid = st_ff.head_v;
   assign out_data  = st_ff.head_d;
endmodule // jcr_buf

// ==== jcr_top.sv ====
// Purpose: Test-port configuration loader with status and frame readback.
// Assumes: TCK is sampled by ref_clk, at least 4 ref_clk per TCK phase.
// Notes:   TDO changes on TCK fall; TDI and TMS are taken on TCK rise.
module jcr_top #(
   parameter logic [10:0] DUMMY_FRAME_WORDS = 11'h010
) (
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        tck,
   input  wire logic        tms,
   input  wire logic        tdi,
   input  wire logic [15:0] frame_word,
   output logic             tdo,
   output logic             tdo_oe,
   output logic             done,
   output logic [15:0]      cmd_word,
   output logic             frame_req,
   output logic             sync_ok
);
   typedef struct packed {
      logic                tck_q;
      jcr_pkg::jcr_tap_t   tap;
      logic [5:0]          ir;
      logic [5:0]          ir_sh;
      logic [15:0]         dr_sh;
      logic [15:0]         out_sh;
      logic [3:0]          bit_cnt;
      logic [3:0]          out_cnt;
      logic                byp;
      logic                tdo;
      logic                tdo_oe;
      logic                done;
      logic [4:0]          sd_cnt;
      logic                sd_busy;
      logic                sd_done;
      jcr_pkg::jcr_pst_t   pst;
      logic                sync_prev;
      logic                sync_ok;
      logic [4:0]          wcnt;
      logic [5:0]          wreg;
      logic [15:0]         cmd;
      logic                read_cfg;
      jcr_pkg::jcr_rsel_t  rsel;
      logic [10:0]         dummy_left;
      logic                frame_req;
      logic                overrun;
      logic                push_v;
      logic [15:0]         push_d;
   } jcr_state_t;

   localparam jcr_state_t ST_RST = '{
      tap:     jcr_pkg::TS_TLR,
      ir:      jcr_pkg::INSTR_BYPASS,
      done:    1'h1,
      pst:     jcr_pkg::PS_HUNT,
      rsel:    jcr_pkg::RS_STAT,
      default: '0
   };

   jcr_state_t         st_ff;
   jcr_state_t         nxt_st;
   jcr_pkg::jcr_pins_t pins_raw;
   jcr_pkg::jcr_pins_t pins_s;
   jcr_pkg::jcr_hdr_t  hdr;
   logic               rise;
   logic               fall;
   logic               load_out;
   logic               buf_in_rdy;
   logic               wv;
   logic [15:0]        wd;
   logic               pk_rdy;
   logic               take;
   logic [15:0]        stat;

   assign pins_raw = '{tck: tck, tms: tms, tdi: tdi};

   jcr_sync #(.W(3)) jcr_sync_inst (
      .clk   (ref_clk),
      .rst_n (rst_n),
      .din   (pins_raw),
      .dout  (pins_s)
   );

   // Parser freezes during shutdown; words queue, then later words are dropped and set overrun
   assign pk_rdy = !st_ff.sd_busy;

   jcr_buf #(.WIDTH(16)) jcr_buf_inst (
      .clk       (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (st_ff.push_v),
      .in_data   (st_ff.push_d),
      .in_ready  (buf_in_rdy),
      .out_valid (wv),
      .out_data  (wd),
      .out_ready (pk_rdy)
   );

   assign rise = pins_s.tck && !st_ff.tck_q;
   assign fall = !pins_s.tck && st_ff.tck_q;
   assign hdr  = wd;
   assign take = wv && pk_rdy;

   always_comb begin
      stat                   = '0;
      stat[jcr_pkg::ST_SYNC] = st_ff.sync_ok;
      stat[jcr_pkg::ST_SHUT] = st_ff.sd_busy;
      stat[jcr_pkg::ST_DONE] = st_ff.done;
      stat[jcr_pkg::ST_READ_CFG] = st_ff.read_cfg;
      stat[jcr_pkg::ST_OVR]  = st_ff.overrun;
   end

   always_comb begin
      nxt_st           = st_ff;
      load_out         = 1'h0;
      nxt_st.tck_q     = pins_s.tck;
      nxt_st.push_v    = 1'h0;
      nxt_st.frame_req = 1'h0;
      if (rise) begin
         nxt_st.tap = jcr_pkg::jcr_next_tap(st_ff.tap, pins_s.tms);
         case (st_ff.tap)
            jcr_pkg::TS_TLR: begin
               nxt_st.ir = jcr_pkg::INSTR_BYPASS;
            end
            jcr_pkg::TS_CAP_IR: begin
               nxt_st.ir_sh = jcr_pkg::IR_CAPTURE;
            end
            jcr_pkg::TS_SHIFT_IR: begin
               // Exit cycle still shifts, so the MSB lands with TMS high
               nxt_st.ir_sh = {pins_s.tdi, st_ff.ir_sh[5:1]};
            end
            jcr_pkg::TS_UPD_IR: begin
               nxt_st.ir = st_ff.ir_sh;
            end
            jcr_pkg::TS_CAP_DR: begin
               nxt_st.bit_cnt = '0;
               nxt_st.out_cnt = '0;
               nxt_st.byp     = 1'h0;
               load_out       = (st_ff.ir == jcr_pkg::INSTR_CFG_OUT);
            end
            jcr_pkg::TS_SHIFT_DR: begin
               if (st_ff.ir == jcr_pkg::INSTR_CFG_IN) begin
                  nxt_st.dr_sh   = {st_ff.dr_sh[14:0], pins_s.tdi};
                  nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
                  if (st_ff.bit_cnt == jcr_pkg::WORD_LAST) begin
                     nxt_st.push_v = 1'h1;
                     nxt_st.push_d = {st_ff.dr_sh[14:0], pins_s.tdi};
                  end
               end else if (st_ff.ir == jcr_pkg::INSTR_CFG_OUT) begin
                  nxt_st.out_sh  = {st_ff.out_sh[14:0], 1'h0};
                  nxt_st.out_cnt = st_ff.out_cnt + 4'h1;
                  load_out       = (st_ff.out_cnt == jcr_pkg::WORD_LAST);
               end else begin
                  nxt_st.byp = pins_s.tdi;
               end
            end
            jcr_pkg::TS_RTI: begin
               if (st_ff.ir == jcr_pkg::INSTR_SHUTDOWN && !st_ff.sd_done) begin
                  nxt_st.sd_busy = 1'h1;
                  if (st_ff.sd_cnt == jcr_pkg::SHUTDOWN_TCK - 5'h01) begin
                     nxt_st.sd_busy = 1'h0;
                     nxt_st.sd_done = 1'h1;
                  end else begin
                     nxt_st.sd_cnt = st_ff.sd_cnt + 5'h01;
                  end
               end
            end
            // Other states leave all shift and config state untouched
            default: begin
               nxt_st.tap = nxt_st.tap;
            end
         endcase
      end
      if (fall) begin
         nxt_st.tdo_oe = 1'h0;
         if (st_ff.tap == jcr_pkg::TS_SHIFT_IR) begin
            nxt_st.tdo_oe = 1'h1;
            nxt_st.tdo    = st_ff.ir_sh[0];
         end else if (st_ff.tap == jcr_pkg::TS_SHIFT_DR) begin
            nxt_st.tdo_oe = 1'h1;
            if (st_ff.ir == jcr_pkg::INSTR_CFG_OUT) begin
               nxt_st.tdo = st_ff.out_sh[15];
            end else if (st_ff.ir == jcr_pkg::INSTR_CFG_IN) begin
               nxt_st.tdo = st_ff.dr_sh[15];
            end else begin
               nxt_st.tdo = st_ff.byp;
            end
         end
      end
      if (load_out) begin
         if (st_ff.rsel == jcr_pkg::RS_FRAME) begin
            if (st_ff.dummy_left != 11'h000) begin
               // Frame buffer is empty on the first pass, so zeros go first
               nxt_st.out_sh     = '0;
               nxt_st.dummy_left = st_ff.dummy_left - 11'h001;
            end else begin
               nxt_st.out_sh    = frame_word;
               nxt_st.frame_req = 1'h1;
            end
         end else begin
            nxt_st.out_sh = stat;
         end
      end
      if (st_ff.push_v && !buf_in_rdy) begin
         nxt_st.overrun = 1'h1;
      end
      if (take) begin
         case (st_ff.pst)
            jcr_pkg::PS_HUNT: begin
               nxt_st.sync_prev = (wd == jcr_pkg::SYNC_HI);
               if (st_ff.sync_prev && wd == jcr_pkg::SYNC_LO) begin
                  nxt_st.sync_ok = 1'h1;
                  nxt_st.pst     = jcr_pkg::PS_HDR;
               end
            end
            jcr_pkg::PS_HDR: begin
               if (hdr.ptype == jcr_pkg::PKT_TYPE1 && hdr.op == jcr_pkg::OP_WRITE
                   && hdr.cnt != 5'h00) begin
                  nxt_st.wcnt = hdr.cnt;
                  nxt_st.wreg = hdr.addr;
                  nxt_st.pst  = jcr_pkg::PS_DATA;
               end else if (hdr.op == jcr_pkg::OP_READ) begin
                  if (hdr.ptype == jcr_pkg::PKT_TYPE2 ||
                      (hdr.ptype == jcr_pkg::PKT_TYPE1 &&
                       hdr.addr == jcr_pkg::REG_FRAME_OUT)) begin
                     nxt_st.rsel       = jcr_pkg::RS_FRAME;
                     nxt_st.dummy_left = DUMMY_FRAME_WORDS;
                  end else if (hdr.ptype == jcr_pkg::PKT_TYPE1 &&
                               hdr.addr == jcr_pkg::REG_STAT) begin
                     nxt_st.rsel = jcr_pkg::RS_STAT;
                  end
               end
            end
            jcr_pkg::PS_DATA: begin
               if (st_ff.wreg == jcr_pkg::REG_CMD) begin
                  nxt_st.cmd = wd;
                  if (wd == jcr_pkg::CMD_READ_CFG) begin
                     nxt_st.read_cfg = 1'h1;
                  end
               end
               nxt_st.wcnt = st_ff.wcnt - 5'h01;
               if (st_ff.wcnt == 5'h01) begin
                  nxt_st.pst = jcr_pkg::PS_HDR;
               end
            end
            default: begin
               nxt_st.pst = jcr_pkg::PS_HUNT;
            end
         endcase
      end
      nxt_st.done = !(nxt_st.sd_busy || nxt_st.sd_done);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tdo       = st_ff.tdo;
   assign tdo_oe    = st_ff.tdo_oe;
   assign done      = st_ff.done;
   assign cmd_word  = st_ff.cmd;
   assign frame_req = st_ff.frame_req;
   assign sync_ok   = st_ff.sync_ok;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_ir_lsb_first: assert property (
      rise && st_ff.tap == jcr_pkg::TS_SHIFT_IR |=> st_ff.ir_sh[5] == $past(pins_s.tdi))
      else $error("instruction bit not taken");
   a_ir_msb_exit: assert property (
      rise && st_ff.tap == jcr_pkg::TS_SHIFT_IR && pins_s.tms
      |=> st_ff.tap == jcr_pkg::TS_EX1_IR && st_ff.ir_sh[5] == $past(pins_s.tdi))
      else $error("instruction msb lost on exit");
   a_word_push: assert property (
      rise && st_ff.tap == jcr_pkg::TS_SHIFT_DR && st_ff.ir == jcr_pkg::INSTR_CFG_IN
      && st_ff.bit_cnt == jcr_pkg::WORD_LAST
      |=> st_ff.push_v && st_ff.push_d[0] == $past(pins_s.tdi))
      else $error("word not pushed on sixteenth bit");
   a_last_lsb: assert property (
      rise && st_ff.tap == jcr_pkg::TS_SHIFT_DR && pins_s.tms
      && st_ff.ir == jcr_pkg::INSTR_CFG_IN && st_ff.bit_cnt == jcr_pkg::WORD_LAST
      |=> st_ff.push_v ##1 !st_ff.push_v)
      else $error("last word not completed on exit");
   a_status_tdo: assert property (
      fall && st_ff.tap == jcr_pkg::TS_SHIFT_DR && st_ff.ir == jcr_pkg::INSTR_CFG_OUT
      |=> st_ff.tdo_oe && st_ff.tdo == $past(st_ff.out_sh[15]))
      else $error("tdo does not show output msb");
   a_sync_accept: assert property (
      take && st_ff.pst == jcr_pkg::PS_HUNT && st_ff.sync_prev && wd == jcr_pkg::SYNC_LO
      |=> st_ff.sync_ok && st_ff.pst == jcr_pkg::PS_HDR)
      else $error("sync pair not accepted");
   a_dummy_first: assert property (
      st_ff.frame_req |-> $past(st_ff.dummy_left) == 11'h000)
      else $error("frame data before dummy frame");
   a_shutdown_len: assert property (
      $rose(st_ff.sd_done) |-> $past(st_ff.sd_cnt) == jcr_pkg::SHUTDOWN_TCK - 5'h01)
      else $error("shutdown length wrong");
   a_done_low: assert property (
      rise && st_ff.tap == jcr_pkg::TS_RTI && st_ff.ir == jcr_pkg::INSTR_SHUTDOWN |=> !done)
      else $error("done high during shutdown");
   a_tdi_ignored: assert property (
      rise && st_ff.tap != jcr_pkg::TS_SHIFT_DR && st_ff.tap != jcr_pkg::TS_SHIFT_IR
      && st_ff.tap != jcr_pkg::TS_CAP_IR |=> $stable(st_ff.dr_sh) && $stable(st_ff.ir_sh))
      else $error("shift state changed outside shift");

   c_shutdown:  cover property ($rose(st_ff.sd_done));
   c_stat_read: cover property (load_out && st_ff.rsel == jcr_pkg::RS_STAT);
   c_frame:     cover property (st_ff.frame_req);
   c_overrun:   cover property ($rose(st_ff.overrun));
endmodule // jcr_top

// ==== jcr_host.sv ====
// Purpose: Test-port host model that clocks TMS/TDI and collects TDO words.
// Assumes: TCK period 32 ns, pins change at TCK fall, TCK idles low.
// Notes:   TDO is taken mid-high phase, well clear of the late TCK-fall update.
module jcr_host (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo_line
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] rx_word;
   event        rx_ev;
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
   end
   task automatic tick(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #16;
      tck = 1'h1;
      #8;
      q = tdo_line;
      #8;
      tck = 1'h0;
   endtask
   // Don't-care cycles carry random TDI so stray capture shows up
   task automatic walk(input logic [7:0] pat, input int n);
      logic q;
      for (int i = 0; i < n; i++) begin
         tick(pat[i], 1'($urandom), q);
      end
   endtask
   task automatic tap_reset();
      walk(8'h1f, 6);
   endtask
   task automatic load_ir(input logic [5:0] ir);
      logic q;
      walk(8'h03, 4);
      for (int i = 0; i < 6; i++) begin
         tick(i == 5, ir[i], q);
      end
      walk(8'h01, 2);
   endtask
   task automatic shift_dr(input logic [15:0] w[$], input logic rd);
      logic        q;
      logic [15:0] acc;
      walk(8'h01, 3);
      for (int k = 0; k < w.size(); k++) begin
         for (int b = 15; b >= 0; b--) begin
            tick((k == w.size() - 1) && (b == 0), w[k][b], q);
            acc = {acc[14:0], q};
         end
         rx_word = acc;
         if (rd) begin
            ->rx_ev;
         end
      end
      walk(8'h01, 2);
   endtask
endmodule // jcr_host

// ==== jtag_config_readback_bench.sv ====
// Purpose: Self-checking bench for status read, shutdown and frame readback.
// Assumes: Host model on the test port, frame words supplied on request.
// Notes:   TDO line is pulled high when released, so a missing enable shows.
module jtag_config_readback_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic        ref_clk;
   logic        rst_n;
   logic        tck;
   logic        tms;
   logic        tdi;
   logic        tdo;
   logic        tdo_oe;
   logic        done;
   logic        frame_req;
   logic        sync_ok;
   logic [15:0] frame_word;
   logic [15:0] cmd_word;
   logic [15:0] rnd;
   logic [15:0] ftbl [4];
   logic [15:0] exp_q[$];
   int          mismatches;
   int          comparisons;
   int          fidx;
   wire         tdo_line = tdo_oe ? tdo : 1'h1;

   jcr_top #(.DUMMY_FRAME_WORDS(11'h002)) jcr_top_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .frame_word(frame_word), .tdo(tdo), .tdo_oe(tdo_oe), .done(done),
      .cmd_word(cmd_word), .frame_req(frame_req), .sync_ok(sync_ok)
   );
   jcr_host jcr_host_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo_line(tdo_line));

   initial begin
      ref_clk = 1'h0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic check(input string name, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic read_words(input logic [15:0] e[$]);
      logic [15:0] r[$];
      foreach (e[i]) begin
         exp_q.push_back(e[i]);
         r.push_back(16'($urandom));
      end
      jcr_host_inst.load_ir(jcr_pkg::INSTR_CFG_OUT);
      jcr_host_inst.shift_dr(r, 1'h1);
   endtask

   // Frame source: next word is offered once the current one is taken
   always @(posedge ref_clk) begin
      if (frame_req === 1'h1) begin
         #1;
         fidx = fidx + 1;
         frame_word = ftbl[fidx[1:0]];
      end
   end

   initial begin
      forever begin
         @(jcr_host_inst.rx_ev);
         if (exp_q.size() == 0) begin
            mismatches++;
            $display("Error tdo word expected none seen %h", jcr_host_inst.rx_word);
         end else begin
            check("tdo word", exp_q.pop_front(), jcr_host_inst.rx_word);
         end
      end
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      mismatches++;
      $display("Error watchdog expected finish seen timeout");
      give_verdict();
   end

   initial begin
      rst_n = 1'h0;
      mismatches = 0;
      comparisons = 0;
      fidx = 0;
      void'($urandom(88));
      foreach (ftbl[i]) ftbl[i] = 16'($urandom);
      frame_word = ftbl[0];
      rnd = 16'($urandom) | 16'h0100;
      repeat (20) @(posedge ref_clk);
      #1;
      rst_n = 1'h1;
      check("done", 16'h0001, {15'h0, done});
      check("cmd_word", 16'h0000, cmd_word);
      check("sync_ok", 16'h0000, {15'h0, sync_ok});
      repeat (3) @(posedge ref_clk);
      // Same launch offset after the edge as reset and the frame source
      #1;
      jcr_host_inst.tap_reset();
      jcr_host_inst.load_ir(jcr_pkg::INSTR_CFG_IN);
      jcr_host_inst.shift_dr('{16'haa99, 16'h5566, 16'h2901, 16'h2000, 16'h2000,
                               16'h2000, 16'h2000}, 1'h0);
      check("sync_ok", 16'h0001, {15'h0, sync_ok});
      read_words('{16'h0005});
      jcr_host_inst.tap_reset();
      jcr_host_inst.load_ir(jcr_pkg::INSTR_CFG_IN);
      jcr_host_inst.shift_dr('{16'hffff, 16'haa99, 16'h5566, 16'h30a1, rnd, 16'h2000},
                             1'h0);
      check("cmd_word", rnd, cmd_word);
      jcr_host_inst.load_ir(jcr_pkg::INSTR_SHUTDOWN);
      // Shutdown only starts counting on the first clock spent in idle
      jcr_host_inst.walk(8'h00, 1);
      check("done", 16'h0000, {15'h0, done});
      jcr_host_inst.walk(8'h00, 23);
      check("done", 16'h0000, {15'h0, done});
      jcr_host_inst.load_ir(jcr_pkg::INSTR_CFG_IN);
      jcr_host_inst.shift_dr('{16'hffff, 16'haa99, 16'h5566, 16'h30a1, 16'h0004, 16'h2901,
                               16'h2000, 16'h2000}, 1'h0);
      check("cmd_word", 16'h0004, cmd_word);
      read_words('{16'h0009});
      jcr_host_inst.load_ir(jcr_pkg::INSTR_CFG_IN);
      jcr_host_inst.shift_dr('{16'h2860, 16'h2000, 16'h2000}, 1'h0);
      read_words('{16'h0000, 16'h0000, ftbl[0], ftbl[1]});
      // Two frame words shown plus one preloaded on the final shift
      check("frame words taken", 16'h0003, 16'(fidx));
      jcr_host_inst.tap_reset();
      check("tdo_oe", 16'h0000, {15'h0, tdo_oe});
      check("pending words", 16'h0000, 16'(exp_q.size()));
      give_verdict();
   end
endmodule // jtag_config_readback_bench
